// File: bench/fbus_master_model.sv
// cyclic master model: posts six-byte parameter jobs on the output block
// assumes the slave's clock; each job is held well past the slave's two-sample capture
`timescale 1ns/1ps
module fbus_master_model (
  input  wire logic        clock,
  input  wire logic [47:0] job_response_block,
  output logic      [47:0] job_request_block
);
  // ************************************************************
  // job posting
  // ************************************************************
  initial job_request_block = 48'h0;

  // code in byte 0, index in byte 1, data msb first in bytes 2..5
  task automatic post(input logic [7:0] c, input logic [7:0] i, input logic [31:0] d,
                      output logic [47:0] r);
    @(posedge clock);
    job_request_block <= {d[7:0], d[15:8], d[23:16], d[31:24], i, c};
    // a real master leaves the job in place; the slave updates its response four cycles after the job is posted
    repeat (12) @(posedge clock);
    r = job_response_block;
  endtask : post
endmodule : fbus_master_model

// File: bench/tb.sv
// self-checking bench for the status packer and parameter job engine
// assumes a 200 MHz clock, synchronous high reset and a classic wishbone port
`timescale 1ns/1ps
module tb;
  logic        clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, main_alarm_ch, pre_alarm_ch, ch_alarms_valid;
  logic [3:0]  uin_level, uin_level_valid, sensor_fault, uin_fault;
  logic [5:0]  relay_out_fired;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [47:0] job_request_block, job_response_block;
  logic [63:0] status_block;
  int          error_cnt, total_checks;

  fbus_status_jobs fbus_status_jobs_i (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .relay_out_fired(relay_out_fired), .main_alarm_ch(main_alarm_ch),
    .pre_alarm_ch(pre_alarm_ch), .ch_alarms_valid(ch_alarms_valid), .uin_level(uin_level),
    .uin_level_valid(uin_level_valid), .sensor_fault(sensor_fault), .uin_fault(uin_fault),
    .job_request_block(job_request_block), .job_response_block(job_response_block),
    .status_block(status_block));
  fbus_master_model fbus_master_model_i (.clock(clock),
    .job_response_block(job_response_block), .job_request_block(job_request_block));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task end_sim;
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  // ack and data are sampled at the rising edge; the request is released at that same edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb

  function automatic logic [47:0] pk(input logic [7:0] c, i, input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24], i, c};
  endfunction : pk

  function automatic logic [63:0] stat_exp(input logic [2:0] ctl);
    logic [7:0] b4;
    for (int k = 0; k < 4; k++) b4[2*k +: 2] = {uin_level_valid[k], uin_level[k]};
    return {5'h00, ctl[1], 1'b0, ctl[0], 8'h00, uin_fault, sensor_fault,
      sensor_fault, |{sensor_fault, uin_fault}, 1'b0, ctl[2], 1'b0, b4,
      ch_alarms_valid[3], 1'b0, pre_alarm_ch[3], main_alarm_ch[3],
      ch_alarms_valid[2], 1'b0, pre_alarm_ch[2], main_alarm_ch[2],
      ch_alarms_valid[1], 1'b0, pre_alarm_ch[1], main_alarm_ch[1],
      ch_alarms_valid[0], 1'b0, pre_alarm_ch[0], main_alarm_ch[0], 2'b00, relay_out_fired};
  endfunction : stat_exp

  task automatic jchk(input logic [7:0] c, i, input logic [31:0] d, input logic [7:0] ec,
                      input logic [31:0] ed, input bit full);
    logic [47:0] r;
    fbus_master_model_i.post(c, i, d, r);
    if (full) chk("job response", r, pk(ec, i, ed));
    else chk("job result", r[15:0], {i, ec});
  endtask : jchk

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_status(input logic [37:0] pins, input logic [2:0] ctl);
    @(posedge clock);
    {relay_out_fired, main_alarm_ch, pre_alarm_ch, ch_alarms_valid, uin_level,
     uin_level_valid, sensor_fault, uin_fault} <= pins;
    wb(1'b1, fbus_status_pkg::REG_CTRL, {29'h0, ctl});
    repeat (6) @(posedge clock);
    chk("status block", status_block, stat_exp(ctl));
    wb(1'b0, fbus_status_pkg::REG_CTRL, 32'h0);
    chk("ctrl readback", rd[2:0], ctl);
  endtask : s_status

  task automatic s_regs;
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", rd, 32'h0);
    wb(1'b1, fbus_status_pkg::REG_SEL, 32'h05);
    wb_sel_i <= 4'h3;
    wb(1'b1, fbus_status_pkg::REG_PDATA, 32'haaaa_0104);
    wb_sel_i <= 4'hf;
    wb(1'b0, fbus_status_pkg::REG_PDATA, 32'h0);
    chk("masked write", rd, 32'h104);
  endtask : s_regs

  // a repeated identical job must not run again, even though the value behind it moved
  task automatic s_once;
    logic [7:0] cnt;
    wb(1'b0, fbus_status_pkg::REG_JOBSTAT, 32'h0);
    cnt = rd[15:8];
    jchk(8'h01, 8'h05, 32'h0, 8'h01, 32'h104, 1'b1);
    wb(1'b1, fbus_status_pkg::REG_PDATA, 32'h222);
    jchk(8'h01, 8'h05, 32'h0, 8'h01, 32'h104, 1'b1);
    wb(1'b0, fbus_status_pkg::REG_JOBSTAT, 32'h0);
    chk("job count", rd[15:0], {cnt + 8'h01, 8'h01});
  endtask : s_once

  task automatic s_jobs;
    jchk(8'h02, 8'h0d, 32'h190, 8'h01, 32'h190, 1'b1);
    wb(1'b1, fbus_status_pkg::REG_SEL, 32'h0d);
    wb(1'b0, fbus_status_pkg::REG_PDATA, 32'h0);
    chk("stored value", rd, 32'h190);
    jchk(8'h02, 8'h1e, 32'hdeadbeef, 8'h01, 32'hdeadbeef, 1'b1);
    jchk(8'h01, 8'h1e, 32'h0, 8'h01, 32'hdeadbeef, 1'b1);
    jchk(8'h02, 8'h01, 32'h100, 8'h08, 32'h100, 1'b1);
    jchk(8'h02, 8'h00, 32'h1_0000, 8'h08, 32'h1_0000, 1'b1);
    jchk(8'h02, 8'h00, 32'hffff, 8'h01, 32'hffff, 1'b1);
    jchk(8'h01, 8'h00, 32'h0, 8'h01, 32'hffff, 1'b1);
    jchk(8'h01, 8'h01, 32'h0, 8'h01, 32'h0, 1'b1);
    jchk(8'h02, 8'h2d, 32'h12, 8'h01, 32'h12, 1'b1);
    jchk(8'h01, 8'h26, 32'h0, 8'h01, 32'h0, 1'b1);
    jchk(8'h01, 8'h27, 32'h0, 8'h07, 32'h0, 1'b0);
    jchk(8'h02, 8'h29, 32'h5, 8'h07, 32'h5, 1'b1);
    jchk(8'h01, 8'h2e, 32'h0, 8'h07, 32'h0, 1'b0);
    jchk(8'h03, 8'h05, 32'h0, 8'h09, 32'h0, 1'b0);
    jchk(8'h00, 8'h00, 32'h0, 8'h09, 32'h0, 1'b0);
  endtask : s_jobs

  // ************************************************************
  // clock, reset and main sequence
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
    wb_sel_i = 4'hf;
    {relay_out_fired, main_alarm_ch, pre_alarm_ch, ch_alarms_valid, uin_level,
     uin_level_valid, sensor_fault, uin_fault} = 38'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("reset status", status_block, 64'h0);
    chk("reset response", job_response_block, 48'h0);
    s_status({6'h3f, {7{4'hf}}}, 3'h7);
    s_status({6'h15, 4'h5, 4'ha, 4'h3, 4'h9, 4'h6, 4'h0, 4'h2}, 3'h2);
    s_status({6'h2a, 4'ha, 4'h5, 4'hc, 4'h6, 4'h9, 4'h8, 4'h0}, 3'h1);
    s_status({6'h00, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0}, 3'h4);
    s_regs();
    s_once();
    s_jobs();
    end_sim();
  end
endmodule : tb

// File: core/fbus_status_jobs.sv
// binary status packer and indexed parameter job engine for a cyclic fieldbus slave
// assumes pins arrive asynchronously, firmware on classic wishbone, one clock
//
// Contract
// - status byte 1 bits 0-5: outputs responded
// - byte 2: channel 1/2 alarms and validity
// - byte 3: same layout for channels 3/4
// - byte 4: universal input level plus validity
// - byte 5: sensor, any-channel, internal faults
// - byte 6: universal input faults, sensor faults repeated
// - byte 8: panel lock bit 2, menu bit 0
// - six-byte job block each direction
// - bytes 2-5 carry 1, 2 or 4 data bytes
// - read result: 1 ok, 7 index, 9 job
// - read response echoes the index
// - write result: 1, 7, 8 rejected, 9
// - write response echoes index and data
// - job block at cyclic bytes 0-5
// - status bytes sit at input bytes 46-53
// - data sent most significant byte first
`timescale 1ns/1ps
module fbus_status_jobs (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [5:0]  relay_out_fired,
  input  wire logic [3:0]  main_alarm_ch,
  input  wire logic [3:0]  pre_alarm_ch,
  input  wire logic [3:0]  ch_alarms_valid,
  input  wire logic [3:0]  uin_level,
  input  wire logic [3:0]  uin_level_valid,
  input  wire logic [3:0]  sensor_fault,
  input  wire logic [3:0]  uin_fault,
  input  wire logic [47:0] job_request_block,
  output logic      [47:0] job_response_block,
  output logic      [63:0] status_block
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [33:0] pins_raw;
  logic [33:0] pins_s;
  logic [47:0] job_s;

  assign pins_raw = {uin_fault, sensor_fault, uin_level_valid, uin_level,
                     ch_alarms_valid, pre_alarm_ch, main_alarm_ch, relay_out_fired};

  sync_two #(.W(34)) u_sync_pins (
    .clock (clock),
    .rst   (rst),
    .d     (pins_raw),
    .q     (pins_s)
  );

  sync_two #(.W(48)) u_sync_job (
    .clock (clock),
    .rst   (rst),
    .d     (job_request_block),
    .q     (job_s)
  );

  logic [5:0] relay_s;
  logic [3:0] main_s;
  logic [3:0] pre_s;
  logic [3:0] valid_s;
  logic [3:0] level_s;
  logic [3:0] level_ok_s;
  logic [3:0] sfault_s;
  logic [3:0] ufault_s;

  assign relay_s    = pins_s[5:0];
  assign main_s     = pins_s[9:6];
  assign pre_s      = pins_s[13:10];
  assign valid_s    = pins_s[17:14];
  assign level_s    = pins_s[21:18];
  assign level_ok_s = pins_s[25:22];
  assign sfault_s   = pins_s[29:26];
  assign ufault_s   = pins_s[33:30];

  // ************************************************************
  // wishbone register port
  // ************************************************************
  logic [2:0]  ctrl_q;
  logic [7:0]  sel_q;
  logic [31:0] wb_dat_q;
  logic        wb_ack_q;
  logic [7:0]  last_res_q;
  logic [7:0]  job_count_q;
  logic [31:0] param_q [fbus_status_pkg::PARAM_COUNT];

  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  wire        bus_wr    = bus_req & wb_we_i;
  wire        hit_ctrl  = wb_adr_i == fbus_status_pkg::REG_CTRL;
  wire        hit_sel   = wb_adr_i == fbus_status_pkg::REG_SEL;
  wire        hit_pdata = wb_adr_i == fbus_status_pkg::REG_PDATA;
  wire        hit_stat  = wb_adr_i == fbus_status_pkg::REG_JOBSTAT;
  wire        sel_known = sel_q <= fbus_status_pkg::IDX_LAST;
  wire [5:0]  sel_slot  = sel_q[5:0];
  wire [31:0] pdata_rd  = sel_known ? param_q[sel_slot] : 32'h0000_0000;
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] pdata_wr  = (pdata_rd & ~byte_mask) | (wb_dat_i & byte_mask);
  wire        sw_pwrite = bus_wr & hit_pdata & sel_known;

  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl  ? {29'h0000_0000, ctrl_q} :
                  hit_sel   ? {24'h00_0000, sel_q} :
                  hit_pdata ? pdata_rd :
                  hit_stat  ? {16'h0000, job_count_q, last_res_q} :
                  32'h0000_0000;

  // unmapped addresses still ack, reading zero and ignoring writes
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= bus_req;
      wb_dat_q <= bus_req ? rd_mux : wb_dat_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= fbus_status_pkg::CTRL_RESET;
      sel_q  <= fbus_status_pkg::SEL_RESET;
    end else begin
      if (bus_wr && hit_ctrl && wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[2:0];
      end
      if (bus_wr && hit_sel && wb_sel_i[0]) begin
        sel_q <= wb_dat_i[7:0];
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // ************************************************************
  // binary status bytes
  // ************************************************************
  logic [7:0] st_b1, st_b2, st_b3, st_b4, st_b5, st_b6, st_b8;
  logic [63:0] status_q;

  always_comb begin
    st_b1 = 8'h00;
    st_b2 = 8'h00;
    st_b3 = 8'h00;
    st_b4 = 8'h00;
    st_b5 = 8'h00;
    st_b6 = 8'h00;
    st_b8 = 8'h00;
    st_b1[5:0] = relay_s;
    st_b2[fbus_status_pkg::ALM_MAIN_LO]  = main_s[0];
    st_b2[fbus_status_pkg::ALM_PRE_LO]   = pre_s[0];
    st_b2[fbus_status_pkg::ALM_VALID_LO] = valid_s[0];
    st_b2[fbus_status_pkg::ALM_MAIN_HI]  = main_s[1];
    st_b2[fbus_status_pkg::ALM_PRE_HI]   = pre_s[1];
    st_b2[fbus_status_pkg::ALM_VALID_HI] = valid_s[1];
    st_b3[fbus_status_pkg::ALM_MAIN_LO]  = main_s[2];
    st_b3[fbus_status_pkg::ALM_PRE_LO]   = pre_s[2];
    st_b3[fbus_status_pkg::ALM_VALID_LO] = valid_s[2];
    st_b3[fbus_status_pkg::ALM_MAIN_HI]  = main_s[3];
    st_b3[fbus_status_pkg::ALM_PRE_HI]   = pre_s[3];
    st_b3[fbus_status_pkg::ALM_VALID_HI] = valid_s[3];
    for (int n = 0; n < 4; n++) begin
      st_b4[2*n]   = level_s[n];
      st_b4[2*n+1] = level_ok_s[n];
    end
    st_b5[7:fbus_status_pkg::FAULT_HI] = sfault_s;
    st_b5[fbus_status_pkg::FAULT_ANY]  = |{sfault_s, ufault_s};
    st_b5[fbus_status_pkg::FAULT_INT]  = ctrl_q[fbus_status_pkg::CTRL_INTFAULT];
    st_b6 = {ufault_s, sfault_s};
    st_b8[fbus_status_pkg::LOCK_BIT] = ctrl_q[fbus_status_pkg::CTRL_LOCK];
    st_b8[fbus_status_pkg::MENU_BIT] = ctrl_q[fbus_status_pkg::CTRL_MENU];
  end

  // byte 1 in the low lane; the framer places the block at input byte 46 onward
  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= 64'h0000_0000_0000_0000;
    end else begin
      status_q <= {st_b8, 8'h00, st_b6, st_b5, st_b4, st_b3, st_b2, st_b1};
    end
  end

  assign status_block = status_q;

  // ************************************************************
  // parameter job engine
  // ************************************************************
  fbus_status_pkg::job_state_t state_q, state_d;
  logic [47:0] cand_q;
  logic [47:0] last_q;
  logic [47:0] resp_q;
  logic        exec_q;

  // a torn multi-byte update is filtered by waiting for two equal samples
  wire        job_new  = job_s != last_q;
  wire        job_go   = (state_q == fbus_status_pkg::ST_CHECK) && (job_s == cand_q)
                         && (job_s != last_q);
  wire [7:0]  j_code   = job_s[7:0];
  wire [7:0]  j_idx    = job_s[15:8];
  wire [31:0] j_data   = {job_s[23:16], job_s[31:24], job_s[39:32], job_s[47:40]};
  wire        idx_known = (j_idx <= fbus_status_pkg::IDX_LAST_LOW) ||
                          ((j_idx > fbus_status_pkg::IDX_HOLE_LAST) &&
                           (j_idx <= fbus_status_pkg::IDX_LAST));
  wire        idx_w2   = (j_idx == fbus_status_pkg::IDX_W2_ZERO) ||
                         ((j_idx >= fbus_status_pkg::IDX_W2_FIRST) &&
                          (j_idx <= fbus_status_pkg::IDX_W2_LAST));
  wire        idx_w4   = (j_idx >= fbus_status_pkg::IDX_W4_FIRST) &&
                         (j_idx <= fbus_status_pkg::IDX_W4_LAST);
  wire        data_fits = idx_w4 || (idx_w2 ? (j_data[31:16] == 16'h0000)
                                            : (j_data[31:8] == 24'h00_0000));
  wire [5:0]  j_slot   = j_idx[5:0];
  wire [31:0] rd_val   = idx_known ? param_q[j_slot] : 32'h0000_0000;
  wire        is_read  = j_code == fbus_status_pkg::JOB_READ;
  wire        is_write = j_code == fbus_status_pkg::JOB_WRITE;
  wire        job_wr   = job_go && is_write && idx_known && data_fits;

  logic [7:0]  res_code;
  logic [31:0] res_data;

  always_comb begin
    res_code = fbus_status_pkg::RES_BAD_JOB;
    res_data = 32'h0000_0000;
    if (is_read) begin
      res_code = idx_known ? fbus_status_pkg::RES_OK : fbus_status_pkg::RES_BAD_INDEX;
      res_data = rd_val;
    end else if (is_write) begin
      res_data = j_data;
      if (!idx_known) begin
        res_code = fbus_status_pkg::RES_BAD_INDEX;
      end else if (!data_fits) begin
        res_code = fbus_status_pkg::RES_BAD_DATA;
      end else begin
        res_code = fbus_status_pkg::RES_OK;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      fbus_status_pkg::ST_IDLE: begin
        if (job_new) begin
          state_d = fbus_status_pkg::ST_CHECK;
        end
      end
      fbus_status_pkg::ST_CHECK: begin
        state_d = fbus_status_pkg::ST_IDLE;
      end
      default: begin
        state_d = fbus_status_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= fbus_status_pkg::ST_IDLE;
      cand_q  <= 48'h0000_0000_0000;
      last_q  <= 48'h0000_0000_0000;
      exec_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cand_q  <= job_s;
      last_q  <= job_go ? job_s : last_q;
      exec_q  <= job_go;
    end
  end

  // response held until the next job is executed; data bytes msb first
  always_ff @(posedge clock) begin
    if (rst) begin
      resp_q      <= 48'h0000_0000_0000;
      last_res_q  <= 8'h00;
      job_count_q <= 8'h00;
    end else if (job_go) begin
      resp_q      <= {res_data[7:0], res_data[15:8], res_data[23:16], res_data[31:24],
                      j_idx, res_code};
      last_res_q  <= res_code;
      job_count_q <= job_count_q + 8'h01;
    end
  end

  assign job_response_block = resp_q;

  // a bus job and a firmware write in one cycle: the bus job wins its slot
  for (genvar k = 0; k < fbus_status_pkg::PARAM_COUNT; k++) begin : g_param
    always_ff @(posedge clock) begin
      if (rst) begin
        param_q[k] <= fbus_status_pkg::PARAM_RESET;
      end else if (job_wr && (j_slot == 6'(k))) begin
        param_q[k] <= j_data;
      end else if (sw_pwrite && (sel_slot == 6'(k))) begin
        param_q[k] <= pdata_wr;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_relay_bits: assert property (status_q[5:0] == $past(relay_s))
    else $error("relay bits not mirrored");
  a_alarm_layout: assert property ({status_q[15], status_q[12], status_q[11], status_q[8]}
      == {$past(valid_s[1]), $past(main_s[1]), $past(valid_s[0]), $past(main_s[0])})
    else $error("channel 1/2 alarm layout wrong");
  a_alarm_upper: assert property ({status_q[21], status_q[17]}
      == {$past(pre_s[3]), $past(pre_s[2])})
    else $error("channel 3/4 pre-alarm layout wrong");
  a_level_pairs: assert property ({status_q[31], status_q[24]}
      == {$past(level_ok_s[3]), $past(level_s[0])})
    else $error("universal input level layout wrong");
  a_fault_summary: assert property (status_q[35] == |status_q[47:40])
    else $error("collective fault does not follow faults");
  a_fault_repeat: assert property (status_q[43:40] == status_q[39:36])
    else $error("sensor faults not repeated in byte 6");
  a_panel_bits: assert property ({status_q[58], status_q[56]} ==
      {$past(ctrl_q[fbus_status_pkg::CTRL_LOCK]), $past(ctrl_q[fbus_status_pkg::CTRL_MENU])})
    else $error("panel lock not shown");
  a_reserved_zero: assert property ({status_q[7:6], status_q[14], status_q[10], status_q[22],
      status_q[18], status_q[34], status_q[32], status_q[63:59], status_q[57],
      status_q[55:48]} == 22'h000000)
    else $error("reserved status bit set");
  a_read_echo: assert property (job_go && is_read |=> resp_q[15:8] == last_q[15:8]
      && resp_q[7:0] == ($past(idx_known) ? fbus_status_pkg::RES_OK
                                           : fbus_status_pkg::RES_BAD_INDEX))
    else $error("read response wrong");
  a_write_echo: assert property (job_go && is_write |=> resp_q[47:16] == last_q[47:16])
    else $error("write data not reflected");
  a_bad_job: assert property (job_go && !is_read && !is_write |=> resp_q[7:0] == 8'h09)
    else $error("invalid job not flagged");
  a_resp_hold: assert property (!exec_q |-> resp_q == $past(resp_q))
    else $error("response changed without a job");
  a_once_per_job: assert property (exec_q |=> !exec_q [*2])
    else $error("job executed twice");

  c_read_ok: cover property (job_go && is_read && idx_known);
  c_write_ok: cover property (job_wr);
  c_write_reject: cover property (job_go && is_write && idx_known && !data_fits);
  c_bad_index: cover property (job_go && !idx_known);

endmodule : fbus_status_jobs

// File: core/fbus_status_pkg.sv
// constants shared by the fieldbus status packer and parameter job engine
// assumes a single 200 MHz clock and a classic wishbone register port
package fbus_status_pkg;

  // ************************************************************
  // cyclic block layout
  // ************************************************************
  localparam int JOB_FIRST_BYTE    = 0;
  localparam int JOB_BYTES         = 6;
  localparam int STATUS_FIRST_BYTE = 46;
  localparam int STATUS_BYTES      = 8;

  // ************************************************************
  // job and result codes
  // ************************************************************
  localparam logic [7:0] JOB_READ      = 8'h01;
  localparam logic [7:0] JOB_WRITE     = 8'h02;
  localparam logic [7:0] RES_OK        = 8'h01;
  localparam logic [7:0] RES_BAD_INDEX = 8'h07;
  localparam logic [7:0] RES_BAD_DATA  = 8'h08;
  localparam logic [7:0] RES_BAD_JOB   = 8'h09;

  // ************************************************************
  // parameter object table
  // ************************************************************
  localparam int         PARAM_COUNT    = 46;
  localparam logic [7:0] IDX_LAST_LOW   = 8'h26;
  localparam logic [7:0] IDX_HOLE_FIRST = 8'h27;
  localparam logic [7:0] IDX_HOLE_LAST  = 8'h29;
  localparam logic [7:0] IDX_LAST       = 8'h2d;
  localparam logic [7:0] IDX_W2_FIRST   = 8'h05;
  localparam logic [7:0] IDX_W2_LAST    = 8'h0d;
  localparam logic [7:0] IDX_W4_FIRST   = 8'h1e;
  localparam logic [7:0] IDX_W4_LAST    = 8'h21;
  localparam logic [7:0] IDX_W2_ZERO    = 8'h00;
  localparam logic [31:0] PARAM_RESET   = 32'h0000_0000;

  // ************************************************************
  // status bit positions inside a byte
  // ************************************************************
  localparam int ALM_MAIN_LO  = 0;
  localparam int ALM_PRE_LO   = 1;
  localparam int ALM_VALID_LO = 3;
  localparam int ALM_MAIN_HI  = 4;
  localparam int ALM_PRE_HI   = 5;
  localparam int ALM_VALID_HI = 7;
  localparam int FAULT_INT    = 1;
  localparam int FAULT_ANY    = 3;
  localparam int FAULT_HI     = 4;
  localparam int MENU_BIT     = 0;
  localparam int LOCK_BIT     = 2;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SEL     = 8'h04;
  localparam logic [7:0] REG_PDATA   = 8'h08;
  localparam logic [7:0] REG_JOBSTAT = 8'h0c;
  localparam int CTRL_MENU     = 0;
  localparam int CTRL_LOCK     = 1;
  localparam int CTRL_INTFAULT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] SEL_RESET  = 8'h00;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_CHECK = 1'b1
  } job_state_t;

endpackage : fbus_status_pkg

// File: core/sync_two.sv
// two-stage level synchroniser, one per group of pin inputs
// assumes the inputs are quasi-static levels from outside the clock domain
`timescale 1ns/1ps
module sync_two #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // the first stage feeds the second and nothing else
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sync_two
